//--- rtcf_reset_seq.v
// Reset time-out sequencer with reset cause flags
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "rtcf_map.vh"
// How it works
// - Crystal: power timer plus 1024 periods, or 1024 alone otherwise and on wake.
// - Crystal with PLL: add PLL lock delay to every crystal time-out.
// - Power-on: clear power-on flag, set time-out and power-down flags.
// - Brown-out: clear brown-out flag, set power-on, time-out and power-down flags.
// - Watchdog reset awake: time-out flag 0, power-down 1, power flags kept.
// - Watchdog in sleep: wake, clear both flags, resume at PC plus one.
// - Master clear awake: restart at 000h, time-out and power-down unchanged.
// - Master clear in sleep or interrupt wake: time-out 1, power-down 0.
// - Interrupt wake resumes at PC plus one, or vector 0004h if enabled.
// - Time-out flag bit 4, power-down bit 3 of status register.
module rtcf_reset_seq #(
	parameter PWRT_CYCLES = `RTCF_PWRT_US * `RTCF_CLK_MHZ,
	parameter PLL_CYCLES = `RTCF_PLL_US * `RTCF_CLK_MHZ
) (
	input wire ref_clk,
	input wire reset,
	input wire por_event,
	input wire bor_event,
	input wire wdt_event,
	input wire master_clear_pin,
	input wire irq_wake,
	input wire sleep_active,
	input wire [12:0] pc_current,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	output reg [7:0] reg_rdata,
	output reg core_reset,
	output reg core_wake,
	output reg [12:0] restart_pc,
	output reg irq_out
);
	localparam ST_RUN = 2'h0;
	localparam ST_WAIT = 2'h1;
	localparam ST_DONE = 2'h2;
	localparam EV_POR = 3'h0;
	localparam EV_BOR = 3'h1;
	localparam EV_WDT = 3'h2;
	localparam EV_MASTER_CLEAR_PIN = 3'h3;
	localparam EV_IRQ = 3'h4;
	localparam EV_NONE = 3'h7;
	// Power-on time-out: crystal mode with the power timer enabled
	localparam [31:0] POR_COUNT = PWRT_CYCLES + `RTCF_OST_CYCLES;

	reg [4:0] sync1_reg;
	reg [4:0] sync2_reg;
	reg [4:0] prev_reg;
	reg [1:0] state_reg;
	reg [31:0] count_reg;
	reg wake_kind_reg;
	reg timeout_flag_n;
	reg powerdown_flag_n;
	reg power_on_flag_n;
	reg brownout_flag_n;
	reg [4:0] irq_stat_reg;
	reg [4:0] irq_mask_reg;
	reg [1:0] osc_mode_reg;
	reg power_timer_enable_n;
	reg global_irq_enable;
	reg [4:0] rise;
	reg [2:0] ev;
	reg is_wake;
	reg [4:0] irq_stat_next;
	reg irq_out_next;
	reg [7:0] rdata_next;
	reg [12:0] wake_pc;
	reg wr_power_control_flags;
	reg wr_mask;
	reg wr_cfg;
	reg rd_stat;

	// Time-out length per oscillator mode and cause
	function [31:0] rtcf_timeout;
		input [1:0] mode;
		input pwrt_off;
		input wake;
		reg [31:0] t;
		begin
			t = 32'h00000000;
			if (!pwrt_off && !wake)
				t = PWRT_CYCLES;
			if (mode == `RTCF_OSC_H4 || mode == `RTCF_OSC_E4)
				t = t + PLL_CYCLES;
			if (mode == `RTCF_OSC_HS || mode == `RTCF_OSC_H4)
				t = t + `RTCF_OST_CYCLES;
			rtcf_timeout = t;
		end
	endfunction

	// Event that wakes the sleeping core instead of resetting it
	function rtcf_wakes;
		input [2:0] kind;
		input asleep;
		begin
			rtcf_wakes = (kind == EV_IRQ) || (kind == EV_WDT && asleep);
		end
	endfunction

	// Register strobe aimed at one address
	function rtcf_hit;
		input strobe;
		input [7:0] addr;
		input [7:0] target;
		begin
			rtcf_hit = strobe && (addr == target);
		end
	endfunction

	always @*
	begin
		rise = sync2_reg & ~prev_reg;
		if (rise[EV_POR])
			ev = EV_POR;
		else if (rise[EV_BOR])
			ev = EV_BOR;
		else if (rise[EV_WDT])
			ev = EV_WDT;
		else if (rise[EV_MASTER_CLEAR_PIN])
			ev = EV_MASTER_CLEAR_PIN;
		else if (rise[EV_IRQ] && sleep_active)
			ev = EV_IRQ;
		else
			ev = EV_NONE;
	end

	// Strobe decode, read mux, sticky cause bits and wake target
	always @*
	begin
		wr_power_control_flags = rtcf_hit(reg_write, reg_addr, `RTCF_ADDR_POWER_CONTROL_FLAGS);
		wr_mask = rtcf_hit(reg_write, reg_addr, `RTCF_ADDR_IRQ_MASK);
		wr_cfg = rtcf_hit(reg_write, reg_addr, `RTCF_ADDR_CFG);
		rd_stat = rtcf_hit(reg_read, reg_addr, `RTCF_ADDR_IRQ_STAT);
		is_wake = rtcf_wakes(ev, sleep_active);
		rdata_next = 8'h00;
		if (reg_read)
		begin
			if (reg_addr == `RTCF_ADDR_STATUS)
				rdata_next = {3'h0, timeout_flag_n, powerdown_flag_n, 3'h0};
			else if (reg_addr == `RTCF_ADDR_POWER_CONTROL_FLAGS)
				rdata_next = {6'h00, power_on_flag_n, brownout_flag_n};
			else if (reg_addr == `RTCF_ADDR_IRQ_STAT)
				rdata_next = {3'h0, irq_stat_reg};
			else if (reg_addr == `RTCF_ADDR_IRQ_MASK)
				rdata_next = {3'h0, irq_mask_reg};
			else if (reg_addr == `RTCF_ADDR_CFG)
				rdata_next = {4'h0, global_irq_enable, power_timer_enable_n, osc_mode_reg};
		end
		// Set beats read-clear when both land in one cycle
		if (rd_stat)
			irq_stat_next = rise;
		else
			irq_stat_next = irq_stat_reg | rise;
		// Tracks the next status, so a read-clear drops the line at once
		irq_out_next = |(irq_stat_next & irq_mask_reg);
		if (ev == EV_IRQ && global_irq_enable)
			wake_pc = `RTCF_PC_VECTOR;
		else
			wake_pc = pc_current + `RTCF_PC_ONE;
	end

	// Two-stage synchroniser and edge history for the event pins
	always @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			sync1_reg <= 5'h00;
			sync2_reg <= 5'h00;
			prev_reg <= 5'h00;
		end
		else
		begin
			sync1_reg <= {irq_wake, master_clear_pin, wdt_event, bor_event, por_event};
			sync2_reg <= sync1_reg;
			prev_reg <= sync2_reg;
		end
	end

	// Read data, interrupt state and configuration
	always @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			reg_rdata <= 8'h00;
			irq_stat_reg <= 5'h00;
			irq_mask_reg <= 5'h00;
			irq_out <= 1'b0;
			osc_mode_reg <= `RTCF_OSC_HS;
			power_timer_enable_n <= 1'b0;
			global_irq_enable <= 1'b0;
		end
		else
		begin
			reg_rdata <= rdata_next;
			irq_stat_reg <= irq_stat_next;
			irq_out <= irq_out_next;
			if (wr_mask)
				irq_mask_reg <= reg_wdata[`RTCF_IRQ_HI:0];
			else if (wr_cfg)
			begin
				osc_mode_reg <= reg_wdata[`RTCF_BIT_OSC_HI:`RTCF_BIT_OSC_LO];
				power_timer_enable_n <= reg_wdata[`RTCF_BIT_PTE];
				global_irq_enable <= reg_wdata[`RTCF_BIT_GIE];
			end
		end
	end

	// Cause flags, time-out counter and core release
	always @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			state_reg <= ST_WAIT;
			count_reg <= POR_COUNT;
			wake_kind_reg <= 1'b0;
			timeout_flag_n <= 1'b1;
			powerdown_flag_n <= 1'b1;
			power_on_flag_n <= 1'b0;
			brownout_flag_n <= 1'b1;
			core_reset <= 1'b1;
			core_wake <= 1'b0;
			restart_pc <= `RTCF_PC_RESET;
		end
		else
		begin
			core_wake <= 1'b0;
			// Software re-arms the cause flags; a hardware event below wins
			if (wr_power_control_flags)
			begin
				power_on_flag_n <= reg_wdata[`RTCF_BIT_POR];
				brownout_flag_n <= reg_wdata[`RTCF_BIT_BOR];
			end
			case (state_reg)
				ST_RUN:
				begin
					if (ev == EV_POR)
					begin
						power_on_flag_n <= 1'b0;
						timeout_flag_n <= 1'b1;
						powerdown_flag_n <= 1'b1;
					end
					else if (ev == EV_BOR)
					begin
						brownout_flag_n <= 1'b0;
						power_on_flag_n <= 1'b1;
						timeout_flag_n <= 1'b1;
						powerdown_flag_n <= 1'b1;
					end
					else if (ev == EV_WDT && !sleep_active)
					begin
						timeout_flag_n <= 1'b0;
						powerdown_flag_n <= 1'b1;
					end
					else if (ev == EV_WDT)
					begin
						timeout_flag_n <= 1'b0;
						powerdown_flag_n <= 1'b0;
					end
					else if (ev == EV_MASTER_CLEAR_PIN && sleep_active)
					begin
						timeout_flag_n <= 1'b1;
						powerdown_flag_n <= 1'b0;
					end
					else if (ev == EV_IRQ)
					begin
						timeout_flag_n <= 1'b1;
						powerdown_flag_n <= 1'b0;
					end
					if (ev != EV_NONE)
					begin
						wake_kind_reg <= is_wake;
						count_reg <= rtcf_timeout(osc_mode_reg, power_timer_enable_n, is_wake);
						state_reg <= ST_WAIT;
						if (is_wake)
							restart_pc <= wake_pc;
						else
						begin
							restart_pc <= `RTCF_PC_RESET;
							core_reset <= 1'b1;
						end
					end
				end
				ST_WAIT:
				begin
					if (count_reg == 32'h00000000)
						state_reg <= ST_DONE;
					else
						count_reg <= count_reg - 32'h00000001;
				end
				default:
				begin
					core_reset <= 1'b0;
					core_wake <= wake_kind_reg;
					state_reg <= ST_RUN;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

//--- rtcf_map.vh
// Constants for the reset time-out and cause flag block
`ifndef RTCF_MAP_VH
`define RTCF_MAP_VH
`define RTCF_ADDR_STATUS 8'h03
`define RTCF_ADDR_POWER_CONTROL_FLAGS 8'h8e
`define RTCF_ADDR_IRQ_STAT 8'hf0
`define RTCF_ADDR_IRQ_MASK 8'hf1
`define RTCF_ADDR_CFG 8'hf2
`define RTCF_BIT_TO 4
`define RTCF_BIT_PD 3
`define RTCF_BIT_POR 1
`define RTCF_BIT_BOR 0
`define RTCF_BIT_OSC_HI 1
`define RTCF_BIT_OSC_LO 0
`define RTCF_BIT_PTE 2
`define RTCF_BIT_GIE 3
`define RTCF_IRQ_HI 4
`define RTCF_OSC_HS 2'h0
`define RTCF_OSC_H4 2'h1
`define RTCF_OSC_EC 2'h2
`define RTCF_OSC_E4 2'h3
`define RTCF_OST_CYCLES 32'h00000400
`define RTCF_PC_RESET 13'h0000
`define RTCF_PC_VECTOR 13'h0004
`define RTCF_PC_ONE 13'h0001
`define RTCF_PWRT_US 72
`define RTCF_PLL_US 2
`define RTCF_CLK_MHZ 50
`endif

//--- rtcf_core_model.sv
// Core model: fixed PC, sleep entered on request, left on wake or reset
`timescale 1ns/1ps
`default_nettype none
module rtcf_core_model (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic sleep_req,
	input wire logic core_reset,
	input wire logic core_wake,
	output logic sleep_active,
	output logic [12:0] pc_current
);
	assign pc_current = 13'h0123;
	always_ff @(posedge ref_clk or posedge reset)
		if (reset)
			sleep_active <= 1'b0;
		else if (core_reset || core_wake)
			sleep_active <= 1'b0;
		else if (sleep_req)
			sleep_active <= 1'b1;
endmodule
`default_nettype wire

//--- rtcf_reset_seq_monitor.sv
// Port checker for the reset sequencer
`timescale 1ns/1ps
`default_nettype none
module rtcf_reset_seq_monitor (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic core_reset,
	input wire logic core_wake,
	input wire logic [12:0] restart_pc,
	input wire logic [12:0] pc_current
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	a_rd_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
		else $error("rdata not idle");
	a_stat_map: assert property ($past(reg_read) && $past(reg_addr) == 8'h03
		|-> reg_rdata[7:5] == 3'h0 && reg_rdata[2:0] == 3'h0) else $error("status bits");
	a_power_control_flags_map: assert property ($past(reg_read) && $past(reg_addr) == 8'h8e
		|-> reg_rdata[7:2] == 6'h00) else $error("power_control_flags bits");
	a_wake_once: assert property (core_wake |=> !core_wake) else $error("wake long");
	a_wake_pc: assert property (core_wake |-> restart_pc == pc_current + 13'h0001
		|| restart_pc == 13'h0004) else $error("wake pc");
	a_wake_run: assert property (core_wake |-> !core_reset && !$past(core_reset))
		else $error("wake in reset");
	a_pc_zero: assert property ($changed(core_reset) |-> restart_pc == 13'h0000)
		else $error("reset pc");
	a_hold_min: assert property ($rose(core_reset) |-> core_reset [*2])
		else $error("reset short");
endmodule
bind rtcf_reset_seq rtcf_reset_seq_monitor i_rtcf_reset_seq_monitor (.ref_clk, .reset,
	.reg_addr, .reg_read, .reg_rdata, .core_reset, .core_wake, .restart_pc, .pc_current);
`default_nettype wire

//--- rtcf_reset_seq_bench.sv
// Testbench for the reset sequencer
`timescale 1ns/1ps
`default_nettype none
module rtcf_reset_seq_bench;
	logic ref_clk = 0, reset = 1, reg_write = 0, reg_read = 0, sleep_req = 0;
	logic [4:0] ev = 5'h00;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
	wire [7:0] reg_rdata;
	wire [12:0] pc_current, restart_pc;
	wire core_reset, core_wake, irq_out, sleep_active;
	int n_mismatch = 0, cmp_count = 0, cyc = 0, m;
	initial forever #10 ref_clk = ~ref_clk;
	rtcf_reset_seq #(.PWRT_CYCLES(20), .PLL_CYCLES(5)) i_rtcf_reset_seq (.ref_clk, .reset,
		.por_event(ev[0]), .bor_event(ev[1]), .wdt_event(ev[2]), .master_clear_pin(ev[3]),
		.irq_wake(ev[4]), .sleep_active, .pc_current, .reg_addr, .reg_wdata, .reg_write,
		.reg_read, .reg_rdata, .core_reset, .core_wake, .restart_pc, .irq_out);
	rtcf_core_model i_rtcf_core_model (.ref_clk, .reset, .sleep_req, .core_reset, .core_wake,
		.sleep_active, .pc_current);
	task summarize;
		$display("cmp_count=%0d n_mismatch=%0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(input logic [12:0] g, input logic [12:0] e);
		cmp_count++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("Error at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge ref_clk);
		reg_write <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge ref_clk);
		reg_read <= 1'b0;
		@(negedge ref_clk);
		chk({5'h00, reg_rdata}, {5'h00, e});
	endtask
	task fire(input int i, input int n);
		int c, k;
		c = 0;
		@(posedge ref_clk);
		ev[i] <= 1'b1;
		for (k = 0; k < 3000; k++)
		begin
			@(posedge ref_clk);
			if (k == 4)
				ev[i] <= 1'b0;
			@(negedge ref_clk);
			if (core_reset === 1'b1)
				c++;
			else if (c > 0 || core_wake === 1'b1)
				break;
		end
		if (n > -2)
			chk(13'(c), 13'(n < 0 ? 0 : n + 2));
	endtask
	task slp(input int i, input int n, input logic [12:0] pc, input logic [7:0] st);
		@(posedge ref_clk);
		sleep_req <= 1'b1;
		@(posedge ref_clk);
		sleep_req <= 1'b0;
		fire(i, n);
		chk(core_wake, 13'(n == -1));
		chk(restart_pc, pc);
		rd(8'h03, st);
	endtask
	always @(posedge ref_clk)
		if (++cyc == 40000)
		begin
			n_mismatch++;
			summarize();
		end
	initial
	begin
		repeat (10) @(posedge ref_clk);
		reset <= 1'b0;
		for (m = 0; m < 2000 && core_reset !== 1'b0; m++) @(negedge ref_clk);
		chk(13'(m), 13'h417);
		rd(8'h03, 8'h18);
		rd(8'h8e, 8'h01);
		rd(8'h55, 8'h00);
		for (m = 0; m < 8; m++)
		begin
			wr(8'hf2, m[7:0]);
			fire(0, (m & 1) * 5 + ((m & 4) ? 0 : 20) + ((m & 2) ? 0 : 1024));
			rd(8'h03, 8'h18);
		end
		wr(8'hf2, 8'h00);
		wr(8'h8e, 8'h03);
		fire(1, 1044);
		rd(8'h03, 8'h18);
		rd(8'h8e, 8'h02);
		rd(8'hf0, 8'h03);
		wr(8'h8e, 8'h03);
		wr(8'hf1, 8'h04);
		fire(2, -2);
		chk(irq_out, 13'h1);
		rd(8'h03, 8'h08);
		rd(8'h8e, 8'h03);
		rd(8'hf0, 8'h04);
		@(negedge ref_clk);
		chk(irq_out, 13'h0);
		fire(3, -2);
		chk(restart_pc, 13'h0000);
		rd(8'h03, 8'h08);
		slp(2, -1, 13'h0124, 8'h00);
		wr(8'hf2, 8'h08);
		slp(4, -1, 13'h0004, 8'h10);
		slp(3, -2, 13'h0000, 8'h10);
		summarize();
	end
endmodule
`default_nettype wire
